// ### logic/secure_watchdog_timer_params.svh
// Offsets, field positions, reset values and timing counts of the watchdog.
// Assumes a 32-bit APB bus that decodes the full byte address.
`ifndef SECURE_WATCHDOG_TIMER_PARAMS_SVH
`define SECURE_WATCHDOG_TIMER_PARAMS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADDR_RELOAD 32'hFFFF_0360
`define ADDR_COUNT 32'hFFFF_0364
`define ADDR_CONTROL 32'hFFFF_0368
`define ADDR_REFRESH 32'hFFFF_036C
`define RESET_CONTROL 16'h0000
`define RESET_RELOAD 16'h3BF8
`define RESET_LFSR 8'h00

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define BIT_COUNT_UP 8
`define BIT_ENABLE 7
`define BIT_PERIODIC 6
`define BIT_WATCHDOG 5
`define BIT_SECURE 4
`define BIT_PRESCALE_HI 3
`define BIT_PRESCALE_LO 2
`define BIT_IRQ_SELECT 1
`define BIT_PD_STOP 0
`define LFSR_TAPS 8'h63

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_FREQ_HZ 25000000
`define OSC_FREQ_HZ 32768
`define OSC_TICK_CYCLES (`CLK_FREQ_HZ / `OSC_FREQ_HZ)

`endif

// ### logic/secure_watchdog_timer_pkg.sv
// Types shared by the watchdog timer.
// Assumes nothing of its surroundings.
package secure_watchdog_timer_pkg;
    typedef logic [15:0] word16_t;
    typedef logic [7:0] lfsr_t;
    typedef logic [31:0] apb_word_t;
endpackage

// ### logic/secure_watchdog_timer.sv
// Watchdog and general 16-bit timer with secure-clear refresh, on APB.
// Assumes rst_b is the power-on reset; other chip resets never reach
// this block, and periphPowerDown and dbgHalt are synchronous to clk.
`include "secure_watchdog_timer_params.svh"

module secure_watchdog_timer #(
    parameter int TICK_DIV = `OSC_TICK_CYCLES
) (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire secure_watchdog_timer_pkg::apb_word_t paddr,
    input wire secure_watchdog_timer_pkg::apb_word_t pwdata,
    output secure_watchdog_timer_pkg::apb_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Chip state.
    input wire logic periphPowerDown,
    input wire logic dbgHalt,
    // Events.
    output logic chipReset,
    output logic wdIrq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic regHit(
        input secure_watchdog_timer_pkg::apb_word_t addr,
        input secure_watchdog_timer_pkg::apb_word_t offset
    );
        return addr == offset;
    endfunction

    // Left-shifting form whose taps follow x^8+x^6+x^5+x+1.
    function automatic secure_watchdog_timer_pkg::lfsr_t lfsrNext(
        input secure_watchdog_timer_pkg::lfsr_t state
    );
        secure_watchdog_timer_pkg::lfsr_t shifted;
        shifted = {state[6:0], 1'b0};
        if (state[7]) begin
            shifted = shifted ^ `LFSR_TAPS;
        end
        return shifted;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    secure_watchdog_timer_pkg::word16_t control_reg;
    secure_watchdog_timer_pkg::word16_t reload_reg;
    secure_watchdog_timer_pkg::word16_t count_reg;
    secure_watchdog_timer_pkg::word16_t count_next;
    secure_watchdog_timer_pkg::lfsr_t lfsr_reg;
    logic ctrlWritten_reg;
    logic [15:0] tickDiv_reg;
    logic tick_reg;
    logic ready_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic accessDone;
    logic accessWr;
    logic refreshWr;
    logic ctrlWr;
    logic reloadWr;
    logic mapped;
    assign accessDone = psel && penable && ready_reg;
    assign accessWr = accessDone && pwrite;
    assign refreshWr = accessWr && regHit(paddr, `ADDR_REFRESH);
    assign ctrlWr = accessWr && regHit(paddr, `ADDR_CONTROL)
        && !ctrlWritten_reg;
    assign reloadWr = accessWr && regHit(paddr, `ADDR_RELOAD)
        && !control_reg[`BIT_WATCHDOG];
    assign mapped = regHit(paddr, `ADDR_RELOAD) || regHit(paddr, `ADDR_COUNT)
        || regHit(paddr, `ADDR_CONTROL) || regHit(paddr, `ADDR_REFRESH);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic wdogMode;
    logic secureMode;
    logic secureBad;
    logic secureOk;
    logic running;
    logic step;
    logic countUp;
    logic wrapHit;
    logic expire;
    logic refreshLoad;
    assign wdogMode = control_reg[`BIT_WATCHDOG];
    assign secureMode = wdogMode && control_reg[`BIT_SECURE];
    // A zero expected value never matches, so a zero seed always resets.
    assign secureBad = refreshWr && secureMode
        && (pwdata[7:0] != lfsr_reg || lfsr_reg == 8'h00);
    assign secureOk = refreshWr && secureMode && !secureBad;
    // Without secure clear the written value is not checked; outside watchdog mode it loads the seed.
    assign refreshLoad = refreshWr && !secureMode || secureOk;
    assign running = control_reg[`BIT_ENABLE]
        && !dbgHalt
        && !(control_reg[`BIT_PD_STOP] && periphPowerDown);
    assign step = running && tick_reg;
    // The watchdog always counts down whatever the direction bit says.
    assign countUp = control_reg[`BIT_COUNT_UP] && !wdogMode;
    assign wrapHit = countUp ? (count_reg == 16'hFFFF) : (count_reg == 16'h0000);
    assign expire = step && wdogMode && count_reg == 16'h0000;

    // ------------------------------------------------------------
    // Oscillator tick
    // ------------------------------------------------------------
    // The 32.768 kHz source is made from clk; every prescaler code
    // divides by one since the others are reserved.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickDiv_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (tickDiv_reg == 16'(TICK_DIV - 1)) begin
            tickDiv_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            tickDiv_reg <= tickDiv_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control and reload registers
    // ------------------------------------------------------------
    // Reserved bits 15:9 are stored as written; software keeps them zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            control_reg <= `RESET_CONTROL;
            ctrlWritten_reg <= 1'b0;
        end else if (ctrlWr) begin
            control_reg <= pwdata[15:0];
            ctrlWritten_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reload_reg <= `RESET_RELOAD;
        end else if (reloadWr) begin
            reload_reg <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        if (refreshLoad) begin
            count_next = reload_reg;
        end else if (expire) begin
            count_next = reload_reg;
        end else if (step && wrapHit) begin
            if (control_reg[`BIT_PERIODIC]) begin
                count_next = reload_reg;
            end else begin
                count_next = countUp ? 16'h0000 : 16'hFFFF;
            end
        end else if (step) begin
            count_next = countUp ? count_reg + 16'h0001 : count_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= `RESET_RELOAD;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // Secure clear sequence
    // ------------------------------------------------------------
    // The sequence has no read path, so software must track it itself.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_reg <= `RESET_LFSR;
        end else if (refreshWr && !wdogMode) begin
            lfsr_reg <= pwdata[7:0];
        end else if (secureOk) begin
            lfsr_reg <= lfsrNext(lfsr_reg);
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chipReset <= 1'b0;
        end else begin
            chipReset <= (expire && !control_reg[`BIT_IRQ_SELECT])
                || secureBad;
        end
    end

    // A set in the same cycle as a refresh write wins over the clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdIrq <= 1'b0;
        end else if ((expire && control_reg[`BIT_IRQ_SELECT])
            || (step && wrapHit && !wdogMode)) begin
            wdIrq <= 1'b1;
        end else if (refreshWr) begin
            wdIrq <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One wait state: the answer is prepared in the first access cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= psel && penable && !ready_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !ready_reg) begin
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            if (!pwrite && regHit(paddr, `ADDR_CONTROL)) begin
                prdata <= {16'h0000, control_reg};
            end else if (!pwrite && regHit(paddr, `ADDR_RELOAD)) begin
                prdata <= {16'h0000, reload_reg};
            end else if (!pwrite && regHit(paddr, `ADDR_COUNT)) begin
                prdata <= {16'h0000, count_reg};
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    assign pready = ready_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence apbWrite(logic [31:0] off);
        psel && penable && pwrite && pready && paddr == off;
    endsequence

    sequence secureRefresh;
        apbWrite(`ADDR_REFRESH) ##0 secureMode;
    endsequence

    AST_CTRL_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
        ctrlWritten_reg |=> $stable(control_reg))
        else $error("control register changed after its single write");

    AST_PLAIN_REFRESH: assert property (@(posedge clk) disable iff (!rst_b)
        apbWrite(`ADDR_REFRESH) ##0 !secureMode
        |=> count_reg == $past(reload_reg) && !chipReset)
        else $error("plain refresh did not reload the count");

    AST_SECURE_BAD: assert property (@(posedge clk) disable iff (!rst_b)
        secureRefresh ##0 (pwdata[7:0] != lfsr_reg) |=> chipReset)
        else $error("mismatched secure refresh gave no reset");

    AST_SECURE_STEP: assert property (@(posedge clk) disable iff (!rst_b)
        secureRefresh ##0 (pwdata[7:0] == lfsr_reg && lfsr_reg != 8'h00)
        |=> lfsr_reg == lfsrNext($past(lfsr_reg)) && count_reg == $past(reload_reg))
        else $error("matching secure refresh did not step and reload");

    AST_ZERO_SEED: assert property (@(posedge clk) disable iff (!rst_b)
        secureRefresh ##0 (lfsr_reg == 8'h00) |=> chipReset)
        else $error("zero expected value did not force a reset");

    AST_WDOG_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
        step && wdogMode && count_reg != 16'h0000 && !refreshWr
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("watchdog count did not step down by one");

    AST_EXPIRE_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        expire && control_reg[`BIT_IRQ_SELECT] |=> wdIrq && !chipReset)
        else $error("expiry with interrupt select gave wrong event");

    AST_EXPIRE_RST: assert property (@(posedge clk) disable iff (!rst_b)
        expire && !control_reg[`BIT_IRQ_SELECT] && !secureBad
        |=> chipReset ##1 !chipReset)
        else $error("expiry without interrupt select gave no reset pulse");

    AST_DEBUG_HALT: assert property (@(posedge clk) disable iff (!rst_b)
        dbgHalt && !refreshWr |=> $stable(count_reg))
        else $error("count moved while debug halted the core");

    AST_DISABLED: assert property (@(posedge clk) disable iff (!rst_b)
        !control_reg[`BIT_ENABLE] && !refreshWr |=> $stable(count_reg))
        else $error("count moved while the timer was disabled");

    AST_PD_STOP: assert property (@(posedge clk) disable iff (!rst_b)
        control_reg[`BIT_PD_STOP] && periphPowerDown && !refreshWr
        |=> $stable(count_reg))
        else $error("count moved in peripheral powerdown with stop set");

    AST_RELOAD_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
        wdogMode |=> $stable(reload_reg) && wdogMode)
        else $error("reload or mode changed in watchdog mode");

    AST_COUNT_UP: assert property (@(posedge clk) disable iff (!rst_b)
        step && countUp && !wrapHit && !refreshWr
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("up counting did not step up by one");

    AST_PERIODIC: assert property (@(posedge clk) disable iff (!rst_b)
        step && wrapHit && !wdogMode && control_reg[`BIT_PERIODIC] && !refreshWr
        |=> count_reg == $past(reload_reg))
        else $error("periodic wrap did not reload");

    AST_TICK_GAP: assert property (@(posedge clk) disable iff (!rst_b)
        tick_reg |=> !tick_reg)
        else $error("oscillator tick longer than one cycle");

    sequence normalWrap;
        step && wrapHit && !wdogMode && !refreshWr;
    endsequence

    AST_CTRL_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
        apbWrite(`ADDR_CONTROL) ##0 !ctrlWritten_reg
        |=> control_reg == $past(pwdata[15:0]) && ctrlWritten_reg)
        else $error("first control write was not stored");

    AST_SEED_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        apbWrite(`ADDR_REFRESH) ##0 !wdogMode |=> lfsr_reg == $past(pwdata[7:0]))
        else $error("refresh write outside watchdog mode did not load the seed");

    AST_PLAIN_NO_CHECK: assert property (@(posedge clk) disable iff (!rst_b)
        apbWrite(`ADDR_REFRESH) ##0 (wdogMode && !control_reg[`BIT_SECURE] && !expire)
        |=> !chipReset && $stable(lfsr_reg))
        else $error("plain refresh was checked against the sequence");

    AST_SECURE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        secureRefresh ##0 (pwdata[7:0] != lfsr_reg) |=> $stable(lfsr_reg))
        else $error("mismatched secure refresh stepped the sequence");

    AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
        wdIrq && !refreshWr |=> wdIrq)
        else $error("interrupt request dropped without a refresh write");

    AST_FREE_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        normalWrap ##0 !control_reg[`BIT_PERIODIC]
        |=> count_reg == ($past(countUp) ? 16'h0000 : 16'hFFFF))
        else $error("free running wrap went to the wrong value");

    AST_WRAP_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        normalWrap |=> wdIrq)
        else $error("timer wrap raised no interrupt request");

    AST_EXPIRE_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
        expire && !refreshLoad |=> count_reg == $past(reload_reg))
        else $error("watchdog expiry did not reload the count");

    AST_RESET_CAUSE: assert property (@(posedge clk) disable iff (!rst_b)
        chipReset |-> $past(expire) && !$past(control_reg[`BIT_IRQ_SELECT])
        || $past(secureBad))
        else $error("reset pulse without expiry or bad refresh");

endmodule

// ### verif/secure_watchdog_timer_bench.sv
// Self-checking bench for the secure watchdog timer, driven over APB.
// Assumes the design package and parameter header are compiled first.
`include "secure_watchdog_timer_params.svh"

module secure_watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic periphPowerDown = 1'b0;
    logic dbgHalt = 1'b0;
    secure_watchdog_timer_pkg::apb_word_t paddr = 32'h0000_0000;
    secure_watchdog_timer_pkg::apb_word_t pwdata = 32'h0000_0000;
    secure_watchdog_timer_pkg::apb_word_t prdata;
    logic pready;
    logic pslverr;
    logic chipReset;
    logic wdIrq;
    int mismatches = 0;
    int n_checks = 0;
    int resetsSeen = 0;
    int waited;
    secure_watchdog_timer_pkg::apb_word_t rd;
    logic err;
    secure_watchdog_timer_pkg::word16_t delta;
    secure_watchdog_timer_pkg::lfsr_t lfsrModel;

    // A short tick keeps every timeout within a few dozen cycles.
    secure_watchdog_timer #(.TICK_DIV(4)) secure_watchdog_timer_i (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periphPowerDown(periphPowerDown), .dbgHalt(dbgHalt),
        .chipReset(chipReset), .wdIrq(wdIrq)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    // Counted mid-cycle so the pulse is never raced against the bench's own edge.
    always @(negedge clk) begin
        if (chipReset === 1'b1) resetsSeen++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        rst_b <= 1'b0;
        periphPowerDown <= 1'b0;
        dbgHalt <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        resetsSeen = 0;
    endtask

    // Two count reads taken exactly 40 cycles, ten ticks, apart.
    task automatic measure();
        secure_watchdog_timer_pkg::word16_t first;
        apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
        first = rd[15:0];
        repeat (36) @(posedge clk);
        apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
        delta = rd[15:0] - first;
    endtask

    task automatic waitResets(input int n, input int bound);
        for (waited = 0; waited < bound && resetsSeen < n; waited++) @(posedge clk);
        chk("reset pulses", n, resetsSeen);
        if (resetsSeen < n) summarize();
    endtask

    task automatic waitIrq(input int bound);
        for (waited = 0; waited < bound && wdIrq !== 1'b1; waited++) @(posedge clk);
        chk("interrupt request", 1, wdIrq);
        if (wdIrq !== 1'b1) summarize();
    endtask

    function automatic secure_watchdog_timer_pkg::lfsr_t lfsrStep(input logic [7:0] s);
        return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
    endfunction

    task automatic secureRun(input logic [7:0] seed, input int steps);
        doReset();
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0100);
        apb(1'b1, `ADDR_REFRESH, {24'h00_0000, seed});
        apb(1'b1, `ADDR_CONTROL, 32'h0000_00B0);
        lfsrModel = seed;
        for (int k = 0; k < steps; k++) begin
            apb(1'b1, `ADDR_REFRESH, {24'h00_0000, lfsrModel});
            lfsrModel = lfsrStep(lfsrModel);
        end
        chk("resets after good refreshes", 0, resetsSeen);
        // A zero seed must fail even on a matching write; others get a wrong value.
        lfsrModel = (seed == 8'h00) ? 8'h00 : (lfsrModel ^ 8'hBA);
        apb(1'b1, `ADDR_REFRESH, {24'h00_0000, lfsrModel});
        waitResets(1, 4);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        waited = $urandom(27245);
        doReset();
        apb(1'b0, `ADDR_RELOAD, 32'h0000_0000);
        chk("reload reset", 32'h0000_3BF8, rd);
        apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
        chk("count reset", 32'h0000_3BF8, rd);
        apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
        chk("control reset", 32'h0000_0000, rd);
        apb(1'b0, `ADDR_REFRESH, 32'h0000_0000);
        chk("refresh read", 32'h0000_0000, rd);
        chk("mapped no error", 0, err);
        apb(1'b0, 32'hFFFF_0370, 32'h0000_0000);
        chk("unmapped error", 1, err);
        measure();
        chk("stopped count", 0, delta);
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0010);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0180);
        apb(1'b1, `ADDR_REFRESH, $urandom);
        periphPowerDown <= 1'b1;
        measure();
        chk("up count", 10, delta);
        dbgHalt <= 1'b1;
        measure();
        chk("halted count", 0, delta);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
        apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
        chk("second control write", 32'h0000_0180, rd);

        doReset();
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0081);
        measure();
        chk("down count", 16'hFFF6, delta);
        periphPowerDown <= 1'b1;
        measure();
        chk("powerdown stop", 0, delta);

        doReset();
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0003);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_00A2);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0055);
        apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
        chk("locked control", 32'h0000_00A2, rd);
        apb(1'b0, `ADDR_RELOAD, 32'h0000_0000);
        chk("locked reload", 32'h0000_0003, rd);
        // The count is still counting down from its reset value until a refresh loads the short reload.
        apb(1'b1, `ADDR_REFRESH, $urandom);
        waitIrq(40);
        chk("no reset on interrupt", 0, resetsSeen);
        apb(1'b1, `ADDR_REFRESH, $urandom);
        @(posedge clk);
        chk("interrupt cleared", 0, wdIrq);

        doReset();
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0007);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_00A0);
        repeat (6) begin
            repeat (12) @(posedge clk);
            apb(1'b1, `ADDR_REFRESH, $urandom);
        end
        chk("refreshed, no reset", 0, resetsSeen);
        waitResets(1, 60);
        chk("no interrupt on reset", 0, wdIrq);

        doReset();
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0002);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_00C0);
        apb(1'b1, `ADDR_REFRESH, $urandom);
        waitIrq(40);
        apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
        chk("periodic reload", 1, rd[15:0] <= 16'h0002);

        doReset();
        apb(1'b1, `ADDR_RELOAD, 32'h0000_0001);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0080);
        apb(1'b1, `ADDR_REFRESH, $urandom);
        waitIrq(40);
        apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
        chk("free running wrap", 1, rd[15:0] >= 16'hFFF0);

        chk("lfsr model step", 32'h0000_0037, lfsrStep(8'hAA));
        chk("lfsr model step", 32'h0000_006E, lfsrStep(8'h37));
        chk("lfsr model step", 32'h0000_00DC, lfsrStep(8'h6E));
        secureRun(8'hAA, 3);
        secureRun($urandom_range(255, 1), $urandom_range(6, 1));
        secureRun(8'h00, 0);
        summarize();
    end

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
